// ---- bench/dmc_channel_test.sv ----
/*
 * Self-checking bench for the transfer channel: Avalon register tasks,
 * timer and receiver triggers, both directions, loop, stop and interrupt.
 * Assumes the memory model answers reads one cycle after MEM_RD.
 */
`timescale 1ns/1ps
module dmc_channel_test;
   logic        CORE_CLK = 1'b0;
   logic        RESETN = 1'b0;
   logic [11:0] AVS_ADDRESS = 12'h000;
   logic        AVS_READ = 1'b0;
   logic        AVS_WRITE = 1'b0;
   logic [31:0] AVS_WRITEDATA = 32'h0;
   logic [31:0] AVS_READDATA;
   logic        AVS_WAITREQUEST;
   logic [3:0]  TIMER_REQ = 4'h0;
   logic [2:0]  RX_VALID = 3'h0;
   logic [11:0] MEM_ADDR;
   logic        MEM_RD;
   logic        MEM_WR;
   logic [7:0]  MEM_WDATA;
   logic [7:0]  MEM_RDATA;
   logic        DMA_IRQ_PENDING;
   int          n_errors = 0;
   int          comparisons = 0;
   int          rd_count = 0;

   always #4 CORE_CLK = ~CORE_CLK;

   dmc_channel i_dmc_channel (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .CORE_CE(1'b1),
      .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
      .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'h1), .AVS_READDATA(AVS_READDATA),
      .AVS_WAITREQUEST(AVS_WAITREQUEST), .TIMER_REQ(TIMER_REQ), .RX_VALID(RX_VALID),
      .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD), .MEM_WR(MEM_WR), .MEM_WDATA(MEM_WDATA),
      .MEM_RDATA(MEM_RDATA), .DMA_IRQ_PENDING(DMA_IRQ_PENDING));

   dmc_mem_model i_dmc_mem_model (.clk(CORE_CLK), .addr(MEM_ADDR), .rd(MEM_RD), .wr(MEM_WR),
      .wdata(MEM_WDATA), .rdata(MEM_RDATA));

   // Counts fetches, so idle periods can be shown to start nothing
   always @(posedge CORE_CLK) begin
      if (MEM_RD === 1'b1) begin
         rd_count <= rd_count + 1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // One bus access; an edge passes first so strobes never change twice
   task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d,
                      output logic [31:0] q);
      @(posedge CORE_CLK);
      AVS_ADDRESS   <= a;
      AVS_WRITEDATA <= {24'h0, d};
      AVS_WRITE     <= w;
      AVS_READ      <= ~w;
      // No local limit: a slave that never answers is caught by the watchdog
      do begin
         @(posedge CORE_CLK);
      end while (AVS_WAITREQUEST !== 1'b0);
      q = AVS_READDATA;
      AVS_WRITE <= 1'b0;
      AVS_READ  <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, q);
      check(q, {24'h0, exp});
   endtask

   // Waits for one peripheral or file write and compares it
   task automatic wait_wr(input logic [11:0] a, input logic [7:0] d);
      int n;
      n = 0;
      do begin
         @(posedge CORE_CLK);
         n++;
      end while (MEM_WR !== 1'b1 && n < 40);
      check({11'h000, MEM_WR, MEM_ADDR, MEM_WDATA}, {11'h000, 1'b1, a, d});
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Watchdog: whole run needs a few hundred cycles
   initial begin
      #(8 * 20000);
      n_errors++;
      close_out();
   end

   initial begin
      repeat (8) @(posedge CORE_CLK);
      RESETN <= 1'b1;
      rd_chk(dmc_pkg::IDX_CTL, 8'h00);
      rd_chk(dmc_pkg::IDX_IRQ_STAT, 8'h00);
      rd_chk(12'h010, 8'h00);
      check({31'h0, DMA_IRQ_PENDING}, 32'h0);
      // Addresses first, enable last
      wr(dmc_pkg::IDX_PERIPH, 8'h40);
      wr(dmc_pkg::IDX_HIGH, 8'h11);
      wr(dmc_pkg::IDX_START, 8'h20);
      wr(dmc_pkg::IDX_END, 8'h23);
      wr(dmc_pkg::IDX_IRQ_MASK, 8'h01);
      rd_chk(dmc_pkg::IDX_PERIPH, 8'h40);
      rd_chk(dmc_pkg::IDX_END, 8'h23);
      // Four single bytes, file to peripheral, one per timer code
      for (int t = 0; t < 4; t++) begin
         wr(dmc_pkg::IDX_CTL, 8'h90 | 8'(t));
         @(posedge CORE_CLK);
         TIMER_REQ <= 4'h1 << t;
         @(posedge CORE_CLK);
         TIMER_REQ <= 4'h0;
         wait_wr(12'hf40, 8'h31 + 8'(t));
         repeat (4) @(posedge CORE_CLK);
         if (t == 0) begin
            rd_chk(dmc_pkg::IDX_START, 8'h21);
         end
      end
      check({31'h0, DMA_IRQ_PENDING}, 32'h1);
      rd_chk(dmc_pkg::IDX_CTL, 8'h13);
      rd_chk(dmc_pkg::IDX_IRQ_STAT, 8'h01);
      rd_chk(dmc_pkg::IDX_IRQ_STAT, 8'h00);
      check({31'h0, DMA_IRQ_PENDING}, 32'h0);
      // Disabled channel ignores a timer pulse
      rd_count = 0;
      @(posedge CORE_CLK);
      TIMER_REQ <= 4'h8;
      @(posedge CORE_CLK);
      TIMER_REQ <= 4'h0;
      repeat (12) @(posedge CORE_CLK);
      check(rd_count, 0);
      // Word moves, peripheral to file, looping, receiver codes
      wr(dmc_pkg::IDX_PERIPH, 8'h50);
      wr(dmc_pkg::IDX_END, 8'h25);
      for (int c = 4; c < 7; c++) begin
         wr(dmc_pkg::IDX_CTL, 8'he8 | 8'(c));
         @(posedge CORE_CLK);
         RX_VALID <= 3'h1 << (c - 4);
         wait_wr(12'h120 + 12'((c - 4) * 2), 8'h61);
         RX_VALID <= 3'h0;
         wait_wr(12'h121 + 12'((c - 4) * 2), 8'h62);
         repeat (4) @(posedge CORE_CLK);
      end
      rd_chk(dmc_pkg::IDX_CTL, 8'hee);
      rd_chk(dmc_pkg::IDX_START, 8'h20);
      rd_chk(dmc_pkg::IDX_IRQ_STAT, 8'h00);
      // Looping channel keeps serving from the reloaded start
      RX_VALID <= 3'h4;
      wait_wr(12'h120, 8'h61);
      RX_VALID <= 3'h0;
      wait_wr(12'h121, 8'h62);
      repeat (4) @(posedge CORE_CLK);
      // Reserved code never requests, whatever is pending
      rd_count = 0;
      wr(dmc_pkg::IDX_CTL, 8'h87);
      @(posedge CORE_CLK);
      TIMER_REQ <= 4'hf;
      RX_VALID  <= 3'h7;
      @(posedge CORE_CLK);
      TIMER_REQ <= 4'h0;
      repeat (12) @(posedge CORE_CLK);
      RX_VALID <= 3'h0;
      check(rd_count, 0);
      // Word whose first byte is the end address moves one byte only
      wr(dmc_pkg::IDX_CTL, 8'h00);
      wr(dmc_pkg::IDX_END, 8'h20);
      wr(dmc_pkg::IDX_CTL, 8'h98);
      rd_count = 0;
      @(posedge CORE_CLK);
      TIMER_REQ <= 4'h1;
      @(posedge CORE_CLK);
      TIMER_REQ <= 4'h0;
      wait_wr(12'hf50, 8'h61);
      repeat (6) @(posedge CORE_CLK);
      check(rd_count, 1);
      check({31'h0, DMA_IRQ_PENDING}, 32'h1);
      rd_chk(dmc_pkg::IDX_CTL, 8'h18);
      // Reset of the stopped channel clears control, mask, address and the interrupt
      RESETN <= 1'b0;
      repeat (2) @(posedge CORE_CLK);
      RESETN <= 1'b1;
      check({31'h0, DMA_IRQ_PENDING}, 32'h0);
      rd_chk(dmc_pkg::IDX_CTL, 8'h00);
      rd_chk(dmc_pkg::IDX_IRQ_MASK, 8'h00);
      rd_chk(dmc_pkg::IDX_START, 8'h00);
      close_out();
   end
endmodule

// ---- bench/dmc_mem_model.sv ----
/*
 * Register file and page-F peripheral registers seen by the channel.
 * Assumes a read answers in the cycle after MEM_RD and that writes land at once.
 */
`timescale 1ns/1ps
module dmc_mem_model (
   input  wire logic        clk,
   input  wire logic [11:0] addr,
   input  wire logic        rd,
   input  wire logic        wr,
   input  wire logic [7:0]  wdata,
   output logic      [7:0]  rdata
);
   logic [7:0] mem [4096];
   logic       rd_q;

   ////////////////////////////////////////////////////////////////////////
   // Known contents, so expected bytes follow from the address
   initial begin
      for (int i = 0; i < 4096; i++) begin
         mem[i] = 8'(i) + 8'h11;
      end
      rdata = 8'h00;
      rd_q  = 1'b0;
   end

   // Data valid one cycle only, then inverted so a late sample shows up
   always @(posedge clk) begin
      rd_q <= rd;
      if (rd) begin
         rdata <= mem[addr];
      end else if (rd_q) begin
         rdata <= ~rdata;
      end
      if (wr) begin
         mem[addr] <= wdata;
      end
   end
endmodule

// ---- src/dmc_channel.sv ----
/*
 * Peripheral transfer channel: Avalon-MM register slave, request selection,
 * byte mover between register file and page-F peripheral registers,
 * loop/stop handling and a read-to-clear interrupt status.
 * Assumes the register file answers a read one cycle after MEM_RD and that
 * timer requests are single-cycle pulses from logic on CORE_CLK.
 */
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module dmc_channel (
   input  wire logic        CORE_CLK,
   input  wire logic        RESETN,
   input  wire logic        CORE_CE,
   input  wire logic [11:0] AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   input  wire logic [3:0]  AVS_BYTEENABLE,
   output logic      [31:0] AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   input  wire logic [3:0]  TIMER_REQ,
   input  wire logic [2:0]  RX_VALID,
   output logic      [11:0] MEM_ADDR,
   output logic             MEM_RD,
   output logic             MEM_WR,
   output logic      [7:0]  MEM_WDATA,
   input  wire logic [7:0]  MEM_RDATA,
   output logic             DMA_IRQ_PENDING
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   logic [7:0]  ctl_q;
   logic [7:0]  ctl_d;
   logic [7:0]  periph_q;
   logic [7:0]  high_q;
   logic [7:0]  end_q;
   logic [7:0]  start_q;
   logic [11:0] cur_q;
   logic [11:0] cur_d;
   logic        stat_q;
   logic        mask_q;
   logic        clr_q;
   logic        pend_q;
   logic        hit_q;
   logic        dir_q;
   logic        word_q;
   logic [1:0]  cnt_q;
   logic        wait_q;
   logic [31:0] rdata_q;
   logic        irq_q;
   logic [11:0] maddr_q;
   logic        mrd_q;
   logic        mwr_q;
   logic [7:0]  mwdata_q;
   dmc_pkg::dmc_state_e st_q;
   dmc_pkg::dmc_state_e st_d;

   ////////////////////////////////////////////////////////////////////////////
   // Avalon decode

   // One wait cycle, then a single ready cycle per request
   wire        bus_req    = AVS_READ | AVS_WRITE;
   wire        bus_first  = bus_req & wait_q;
   wire        bus_accept = bus_req & ~wait_q;
   wire        wr_ok      = bus_accept & AVS_WRITE & AVS_BYTEENABLE[0];
   wire [7:0]  wbyte      = AVS_WRITEDATA[7:0];
   wire        wr_ctl     = wr_ok & (AVS_ADDRESS == dmc_pkg::IDX_CTL);
   wire        wr_periph  = wr_ok & (AVS_ADDRESS == dmc_pkg::IDX_PERIPH);
   wire        wr_high    = wr_ok & (AVS_ADDRESS == dmc_pkg::IDX_HIGH);
   wire        wr_start   = wr_ok & (AVS_ADDRESS == dmc_pkg::IDX_START);
   wire        wr_end     = wr_ok & (AVS_ADDRESS == dmc_pkg::IDX_END);
   wire        wr_mask    = wr_ok & (AVS_ADDRESS == dmc_pkg::IDX_IRQ_MASK);
   wire        rd_stat    = bus_accept & AVS_READ & (AVS_ADDRESS == dmc_pkg::IDX_IRQ_STAT);

   // Read mux; the start slot shows the live address, unmapped reads as zero
   wire [7:0]  rd_mux =
      (AVS_ADDRESS == dmc_pkg::IDX_CTL)      ? ctl_q :
      (AVS_ADDRESS == dmc_pkg::IDX_PERIPH)   ? periph_q :
      (AVS_ADDRESS == dmc_pkg::IDX_HIGH)     ? high_q :
      (AVS_ADDRESS == dmc_pkg::IDX_START)    ? cur_q[7:0] :
      (AVS_ADDRESS == dmc_pkg::IDX_END)      ? end_q :
      (AVS_ADDRESS == dmc_pkg::IDX_IRQ_STAT) ? {7'h00, stat_q} :
      (AVS_ADDRESS == dmc_pkg::IDX_IRQ_MASK) ? {7'h00, mask_q} : 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Address and request selection

   // Start and end share the nibble register
   wire [11:0] start_addr = {high_q[dmc_pkg::HI_START_H:dmc_pkg::HI_START_L], start_q};
   wire [11:0] end_addr   = {high_q[dmc_pkg::HI_END_H:dmc_pkg::HI_END_L], end_q};
   wire [7:0]  periph_lo  = periph_q + {6'h00, cnt_q};
   wire [11:0] periph_adr = {dmc_pkg::PERIPH_PAGE, periph_lo};
   wire [11:0] src_addr   = dir_q ? periph_adr : cur_q;
   wire [11:0] dst_addr   = dir_q ? cur_q : periph_adr;

   wire        en       = ctl_q[dmc_pkg::CTL_EN];
   wire [2:0]  trg      = ctl_q[dmc_pkg::CTL_TRG_H:dmc_pkg::CTL_TRG_L];
   wire        trg_tmr  = ~trg[2];
   wire        tmr_hit  = trg_tmr & TIMER_REQ[trg[1:0]];
   wire        rx_sel   = trg[2] & (trg != dmc_pkg::TRG_RESERVED);
   wire        rx_hit   = rx_sel & RX_VALID[trg[1:0]];
   wire        serve    = (st_q == dmc_pkg::ST_IDLE) & en & ((trg_tmr & pend_q) | rx_hit);
   wire [1:0]  need     = word_q ? dmc_pkg::BYTES_TWO : dmc_pkg::BYTES_ONE;
   wire        step     = st_q == dmc_pkg::ST_STEP;
   wire        fin      = step & (hit_q | (cnt_q == need));
   wire        blk_done = fin & hit_q;
   wire        stat_set = blk_done & ctl_q[dmc_pkg::CTL_IE];
   wire        en_rise  = wr_ctl & wbyte[dmc_pkg::CTL_EN] & ~en;
   wire        sw_cur   = wr_start | wr_high | en_rise;

   ////////////////////////////////////////////////////////////////////////////
   // Next-value logic

   // Engine state sequence: read source, capture, write destination, step
   always_comb begin
      st_d = st_q;
      case (st_q)
         dmc_pkg::ST_IDLE: if (serve) st_d = dmc_pkg::ST_RD;
         dmc_pkg::ST_RD:   st_d = dmc_pkg::ST_CAP;
         dmc_pkg::ST_CAP:  st_d = dmc_pkg::ST_WR;
         dmc_pkg::ST_WR:   st_d = dmc_pkg::ST_STEP;
         dmc_pkg::ST_STEP: st_d = fin ? dmc_pkg::ST_IDLE : dmc_pkg::ST_RD;
         default:          st_d = dmc_pkg::ST_IDLE;
      endcase
   end

   // Software write beats the engine so a re-enable is never undone
   always_comb begin
      ctl_d = ctl_q;
      if (blk_done & ~ctl_q[dmc_pkg::CTL_LOOP]) begin
         ctl_d[dmc_pkg::CTL_EN] = 1'b0;
      end
      if (wr_ctl) begin
         ctl_d = wbyte;
      end
   end

   // Current address: software load, loop reload or per-byte advance
   always_comb begin
      cur_d = cur_q;
      if (st_q == dmc_pkg::ST_WR) begin
         cur_d = cur_q + 12'h001;
      end
      if (blk_done & ctl_q[dmc_pkg::CTL_LOOP]) begin
         cur_d = start_addr;
      end
      if (wr_start) begin
         cur_d = {cur_q[11:8], wbyte};
      end
      if (wr_high) begin
         cur_d = {wbyte[dmc_pkg::HI_START_H:dmc_pkg::HI_START_L], cur_d[7:0]};
      end
      if (en_rise) begin
         cur_d = start_addr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register storage

   dmc_reg8 #(.RESET_VAL(dmc_pkg::RST_BYTE)) u_periph (
      .clk   (CORE_CLK),
      .rst_n (RESETN),
      .ce    (CORE_CE),
      .we    (wr_periph),
      .d     (wbyte),
      .q     (periph_q)
   );

   dmc_reg8 #(.RESET_VAL(dmc_pkg::RST_BYTE)) u_high (
      .clk   (CORE_CLK),
      .rst_n (RESETN),
      .ce    (CORE_CE),
      .we    (wr_high),
      .d     (wbyte),
      .q     (high_q)
   );

   dmc_reg8 #(.RESET_VAL(dmc_pkg::RST_BYTE)) u_start (
      .clk   (CORE_CLK),
      .rst_n (RESETN),
      .ce    (CORE_CE),
      .we    (wr_start),
      .d     (wbyte),
      .q     (start_q)
   );

   dmc_reg8 #(.RESET_VAL(dmc_pkg::RST_BYTE)) u_end (
      .clk   (CORE_CLK),
      .rst_n (RESETN),
      .ce    (CORE_CE),
      .we    (wr_end),
      .d     (wbyte),
      .q     (end_q)
   );

   // Control, current address and interrupt state
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         ctl_q  <= dmc_pkg::RST_CTL;
         cur_q  <= 12'h000;
         stat_q <= dmc_pkg::RST_FLAG;
         mask_q <= dmc_pkg::RST_FLAG;
         irq_q  <= 1'b0;
      end else if (CORE_CE) begin
         ctl_q  <= ctl_d;
         cur_q  <= cur_d;
         stat_q <= (stat_q & ~(rd_stat & clr_q)) | stat_set;
         mask_q <= wr_mask ? wbyte[0] : mask_q;
         irq_q  <= ((stat_q & ~(rd_stat & clr_q)) | stat_set) & mask_q;
      end
   end

   // Bus slave response
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         wait_q  <= 1'b1;
         rdata_q <= 32'h0000_0000;
         clr_q   <= 1'b0;
      end else if (CORE_CE) begin
         wait_q  <= ~bus_first;
         if (bus_first & AVS_READ) begin
            rdata_q <= {24'h00_0000, rd_mux};
            clr_q   <= stat_q;
         end
      end
   end

   // Timer pulse latch; a pulse in the serving cycle is kept
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         pend_q <= 1'b0;
      end else if (CORE_CE) begin
         pend_q <= (pend_q & ~serve & en) | (tmr_hit & en);
      end
   end

   // Engine state and per-request captures
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         st_q   <= dmc_pkg::ST_IDLE;
         hit_q  <= 1'b0;
         dir_q  <= 1'b0;
         word_q <= 1'b0;
         cnt_q  <= 2'h0;
      end else if (CORE_CE) begin
         st_q <= st_d;
         if (serve) begin
            hit_q  <= 1'b0;
            cnt_q  <= 2'h0;
            dir_q  <= ctl_q[dmc_pkg::CTL_DIR];
            word_q <= ctl_q[dmc_pkg::CTL_WORD];
         end else if (st_q == dmc_pkg::ST_WR) begin
            hit_q <= hit_q | (cur_q == end_addr);
            cnt_q <= cnt_q + 2'h1;
         end
      end
   end

   // Memory port: source read, then destination write with captured byte
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         maddr_q  <= 12'h000;
         mrd_q    <= 1'b0;
         mwr_q    <= 1'b0;
         mwdata_q <= 8'h00;
      end else if (CORE_CE) begin
         mrd_q <= (st_d == dmc_pkg::ST_RD);
         mwr_q <= (st_d == dmc_pkg::ST_WR);
         if (st_d == dmc_pkg::ST_RD) begin
            maddr_q <= (st_q == dmc_pkg::ST_IDLE) ? (ctl_q[dmc_pkg::CTL_DIR] ?
                       {dmc_pkg::PERIPH_PAGE, periph_q} : cur_q) : src_addr;
         end else if (st_d == dmc_pkg::ST_WR) begin
            maddr_q  <= dst_addr;
            mwdata_q <= MEM_RDATA;
         end
      end
   end

   assign AVS_READDATA    = rdata_q;
   assign AVS_WAITREQUEST = wait_q;
   assign MEM_ADDR        = maddr_q;
   assign MEM_RD          = mrd_q;
   assign MEM_WR          = mwr_q;
   assign MEM_WDATA       = mwdata_q;
   assign DMA_IRQ_PENDING = irq_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RESETN || !CORE_CE);

   sequence s_rd_wr;
      MEM_RD ##1 !MEM_RD ##1 MEM_WR;
   endsequence

   // A request is answered by exactly one low waitrequest cycle
   a_wait_one_low: assert property (bus_first |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
      else $error("waitrequest not a single low cycle");
   // Every source read is followed by its destination write
   a_read_then_write: assert property (MEM_RD |-> s_rd_wr)
      else $error("read not followed by write two cycles later");
   // Writes to the peripheral side land on page F
   a_periph_page: assert property (MEM_WR && !dir_q |-> MEM_ADDR[11:8] == dmc_pkg::PERIPH_PAGE)
      else $error("peripheral write off page F");
   // Disabled channel stays idle
   a_idle_when_off: assert property (st_q == dmc_pkg::ST_IDLE && !en |=> st_q == dmc_pkg::ST_IDLE)
      else $error("transfer started while disabled");
   // Reserved trigger never starts a transfer
   a_reserved_trig: assert property (st_q == dmc_pkg::ST_IDLE && trg == dmc_pkg::TRG_RESERVED
                                     |=> st_q == dmc_pkg::ST_IDLE)
      else $error("reserved trigger started a transfer");
   // Status only rises with interrupts enabled
   a_irq_gated: assert property ($rose(stat_q) |-> $past(ctl_q[dmc_pkg::CTL_IE]))
      else $error("status set with interrupt disabled");
   // Non-loop completion clears enable
   a_stop_at_end: assert property (blk_done && !ctl_q[dmc_pkg::CTL_LOOP] && !wr_ctl |=> !en)
      else $error("enable still set after final transfer");
   // Loop completion reloads start and stays enabled
   a_loop_reload: assert property (blk_done && en && ctl_q[dmc_pkg::CTL_LOOP] && !wr_ctl && !sw_cur
                                   |=> en && cur_q == $past(start_addr))
      else $error("loop did not reload start address");
   // Word mode moves two bytes unless the end is reached first
   a_word_bytes: assert property (serve && ctl_q[dmc_pkg::CTL_WORD]
                                  |=> s_rd_wr ##2 (hit_q || MEM_RD))
      else $error("second byte of word not started");
   // Each byte advances the current address by one
   a_addr_step: assert property (st_q == dmc_pkg::ST_WR && !sw_cur |=> cur_q == $past(cur_q) + 12'h001)
      else $error("current address did not advance");

endmodule

// ---- src/dmc_pkg.sv ----
/*
 * Constants for the single peripheral transfer channel: register indices,
 * control field positions, reset values and engine state codes.
 * Assumes the Avalon-MM slave sees a word index; byte address is four times it.
 */
package dmc_pkg;

   // Register word indices
   localparam logic [11:0] IDX_CTL       = 12'hfb0;
   localparam logic [11:0] IDX_PERIPH    = 12'hfb1;
   localparam logic [11:0] IDX_HIGH      = 12'hfb2;
   localparam logic [11:0] IDX_START     = 12'hfb3;
   localparam logic [11:0] IDX_END       = 12'hfb4;
   localparam logic [11:0] IDX_IRQ_STAT  = 12'hfb5;
   localparam logic [11:0] IDX_IRQ_MASK  = 12'hfb6;

   // Control field positions
   localparam int CTL_EN    = 7;
   localparam int CTL_LOOP  = 6;
   localparam int CTL_DIR   = 5;
   localparam int CTL_IE    = 4;
   localparam int CTL_WORD  = 3;
   localparam int CTL_TRG_H = 2;
   localparam int CTL_TRG_L = 0;

   // High-nibble register layout
   localparam int HI_END_H   = 7;
   localparam int HI_END_L   = 4;
   localparam int HI_START_H = 3;
   localparam int HI_START_L = 0;

   // Trigger codes
   localparam logic [2:0] TRG_RESERVED = 3'h7;

   // Reset values
   localparam logic [7:0] RST_CTL   = 8'h00;
   localparam logic [7:0] RST_BYTE  = 8'h00;
   localparam logic [0:0] RST_FLAG  = 1'h0;

   // Peripheral register page
   localparam logic [3:0] PERIPH_PAGE = 4'hf;

   // Byte counts per request
   localparam logic [1:0] BYTES_ONE = 2'h1;
   localparam logic [1:0] BYTES_TWO = 2'h2;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RD   = 3'b001,
      ST_CAP  = 3'b010,
      ST_WR   = 3'b011,
      ST_STEP = 3'b100
   } dmc_state_e;

endpackage

// ---- src/dmc_reg8.sv ----
/*
 * One software-written byte register with clock enable.
 * Assumes the write strobe is already decoded and accepted on this clock.
 */
`timescale 1ns/1ps
module dmc_reg8 #(
   parameter logic [7:0] RESET_VAL = 8'h00
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       ce,
   input  wire logic       we,
   input  wire logic [7:0] d,
   output logic      [7:0] q
);

   // Byte store, frozen while the enable is low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= RESET_VAL;
      end else if (ce && we) begin
         q <= d;
      end
   end

endmodule
